// ---- verilog/psf_defines.vh ----
// Constants for the special flag bank: offsets, bit positions, timing
// Notes on behaviour
// - Input edge latches input level into catch flag
// - One edge per catch flag per scan
// - Run program while start flag set
// - Initialize pulse lasts exactly the first scan
// - Kill flag forces every output off
// - Carry or borrow sets carry flag, shifts too
// - Program execution error sets fault flag
// - Link error sticky until loader clears or power-off
// - Inhibit stops link at base station only, kept across power-off
// - Version 6 base: flag reinitializes link system
// - Version 5 base: reinit flag does nothing
// - Slave: 800 ms silence sets stop flag
// - Expansion station: flag inert and reads zero
// - Second clear holds second tick at zero
// - Second tick: 500 ms high, 500 ms low
// - Tenth tick: 50 ms high, 50 ms low
// - Hundredth tick: 5 ms high, 5 ms low
// - Preset flag set on change, cleared on download
// - Catch and init flags writable by loader only
// - Counter clear flag kept while CPU stopped
// - Counter clear flag holds counter at zero
// - Running indicator high while controller runs
`ifndef PSF_DEFINES_VH
`define PSF_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PSF_ADDR_W 4
`define PSF_DATA_W 8
`define PSF_REG_CATCH 4'h0
`define PSF_REG_CTRL 4'h1
`define PSF_REG_TICK 4'h2
`define PSF_REG_INFO 4'h3

// ----------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------
`define PSF_C_RUN 0
`define PSF_C_FIRST 1
`define PSF_C_KILL 2
`define PSF_C_CARRY 3
`define PSF_C_FAULT 4
`define PSF_C_LFAULT 5
`define PSF_C_INHIBIT 6
`define PSF_C_REINIT 7

// ----------------------------------------------------------------
// Tick register bits
// ----------------------------------------------------------------
`define PSF_T_SCLR 0
`define PSF_T_SEC 1
`define PSF_T_TENTH 2
`define PSF_T_HUND 3
`define PSF_T_PRESET 4
`define PSF_T_FCCLR 5
`define PSF_T_WRAP 6
`define PSF_T_RUNNING 7

// ----------------------------------------------------------------
// Station roles
// ----------------------------------------------------------------
`define PSF_ROLE_BASE 2'h0
`define PSF_ROLE_SLAVE 2'h1
`define PSF_ROLE_EXP 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSF_CLK_NS 100
`define PSF_MS_NS 1000000
`define PSF_MS_CYCLES (`PSF_MS_NS / `PSF_CLK_NS)
`define PSF_HUND_HALF_MS 5
`define PSF_DECADE 10
`define PSF_LINK_SILENCE_MS 800

`endif

// ---- verilog/psf_flag_bank.v ----
// Special status and control flag bank of the controller
`include "psf_defines.vh"

module psf_flag_bank #(
    parameter MS_CYCLES = `PSF_MS_CYCLES,
    parameter SILENCE_MS = `PSF_LINK_SILENCE_MS
) (
    input wire mclk, // 10 MHz clock
    input wire rst_b, // Power-on reset, async, low
    input wire [3:0] reg_addr, // Register address
    input wire [7:0] reg_wdata, // Register write data
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    output reg [7:0] reg_rdata, // Read data, cycle after strobe
    input wire [7:0] catch_in, // First eight inputs
    input wire scan_end, // Pulse at the end of each scan
    input wire carry_set, // Add carry, borrow or shift out one
    input wire carry_clr, // Shift or arithmetic result no carry
    input wire prog_error, // Execution error pulse
    input wire link_error, // Link communication error pulse
    input wire link_frame_ok, // Correct link data received
    input wire [1:0] station_role, // Base, slave or expansion
    input wire sysver_ge6, // System program version 6 or later
    input wire preset_changed, // Loader altered a preset
    input wire program_download, // Program transferred
    input wire loader_preset_clear, // Changed presets cleared
    input wire fc_overflow, // Fast counter overflow pulse
    input wire fc_hard_reset, // Fast counter hard reset input
    input wire nv_run, // Backed-up start flag
    input wire nv_inhibit, // Backed-up inhibit flag
    input wire nv_preset, // Backed-up preset flag
    output wire program_run, // Execute user program
    output wire first_scan_pulse, // First scan after start
    output wire outputs_kill_flag, // Force all outputs off
    output wire link_halt, // Stop link communication
    output reg link_reinit, // One-cycle link reinitialize
    output wire fast_counter_clear_flag, // Hold counter at zero
    output wire running_indicator, // Controller running
    output wire second_tick, // 1 s clock
    output wire tenth_second_tick, // 100 ms clock
    output wire hundredth_second_tick, // 10 ms clock
    output wire [7:0] ctrl_flags, // Start..reinit flags, for backup
    output wire [7:0] tick_flags // Clear..running flags, for backup
);

    // ----------------------------------------------------------------
    // Flag state
    // ----------------------------------------------------------------
    reg [7:0] catch_flag;
    reg [7:0] catch_armed;
    reg [7:0] catch_prev;
    reg run_control_flag;
    reg first_flag;
    reg first_pending;
    reg run_prev;
    reg kill_flag;
    reg carry_borrow_flag;
    reg program_fault_flag;
    reg link_fault_flag;
    reg link_inhibit_flag;
    reg link_reinit_or_timeout_flag;
    reg reinit_prev;
    reg second_tick_clear;
    reg sec_q;
    reg tenth_q;
    reg hund_q;
    reg preset_modified_flag;
    reg fc_clear_q;
    reg fast_counter_wrap_flag;
    reg booted;
    reg [13:0] ms_cnt;
    reg [2:0] hund_cnt;
    reg [3:0] tenth_cnt;
    reg [3:0] sec_cnt;
    reg [9:0] silence_cnt;

    wire wr_catch = reg_wr && (reg_addr == `PSF_REG_CATCH);
    wire wr_ctrl = reg_wr && (reg_addr == `PSF_REG_CTRL);
    wire wr_tick = reg_wr && (reg_addr == `PSF_REG_TICK);
    wire is_base = (station_role == `PSF_ROLE_BASE);
    wire is_slave = (station_role == `PSF_ROLE_SLAVE);
    wire ms_tick = (ms_cnt == MS_CYCLES[13:0] - 14'h1);
    wire hund_edge = ms_tick &&
        (hund_cnt == `PSF_HUND_HALF_MS - 3'h1);
    wire tenth_edge = hund_edge && (tenth_cnt == `PSF_DECADE - 4'h1);
    wire sec_edge = tenth_edge && (sec_cnt == `PSF_DECADE - 4'h1);
    wire [7:0] catch_edge = catch_in ^ catch_prev;
    wire stopped = !run_control_flag;

    // Write data bit, or keep when this word is not written
    function wr_bit;
        input sel;
        input din;
        input cur;
        begin
            wr_bit = sel ? din : cur;
        end
    endfunction

    // ----------------------------------------------------------------
    // Catch input latches
    // ----------------------------------------------------------------
    // Catch flags keep operating while stopped
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            catch_flag <= 8'h00;
            catch_armed <= 8'hff;
            catch_prev <= 8'h00;
        end else begin
            catch_prev <= catch_in;
            if (wr_catch) begin
                catch_flag <= reg_wdata;
            end
            catch_flag <= (wr_catch ? reg_wdata : catch_flag) &
                ~(catch_edge & catch_armed) |
                (catch_edge & catch_armed & catch_in);
            if (scan_end) begin
                catch_armed <= 8'hff;
            end else begin
                catch_armed <= catch_armed & ~catch_edge;
            end
        end
    end

    // ----------------------------------------------------------------
    // Run control and scan flags
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            booted <= 1'b0;
            run_control_flag <= 1'b0;
            run_prev <= 1'b0;
            first_flag <= 1'b0;
            first_pending <= 1'b0;
            kill_flag <= 1'b0;
            carry_borrow_flag <= 1'b0;
            program_fault_flag <= 1'b0;
        end else begin
            booted <= 1'b1;
            run_prev <= run_control_flag;
            if (!booted) begin
                run_control_flag <= nv_run;
            end else begin
                run_control_flag <= wr_bit(wr_ctrl,
                    reg_wdata[`PSF_C_RUN], run_control_flag);
            end
            if (stopped) begin
                first_flag <= 1'b0;
                first_pending <= 1'b0;
                kill_flag <= 1'b0;
                carry_borrow_flag <= 1'b0;
                program_fault_flag <= 1'b0;
            end else begin
                if (!run_prev) begin
                    first_flag <= 1'b1;
                    first_pending <= 1'b1;
                end else if (scan_end && first_pending) begin
                    first_flag <= 1'b0;
                    first_pending <= 1'b0;
                end else begin
                    first_flag <= wr_bit(wr_ctrl,
                        reg_wdata[`PSF_C_FIRST], first_flag);
                end
                kill_flag <= wr_bit(wr_ctrl, reg_wdata[`PSF_C_KILL],
                    kill_flag);
                carry_borrow_flag <= carry_set |
                    (~carry_clr & wr_bit(wr_ctrl,
                    reg_wdata[`PSF_C_CARRY], carry_borrow_flag));
                program_fault_flag <= prog_error | wr_bit(wr_ctrl,
                    reg_wdata[`PSF_C_FAULT], program_fault_flag);
            end
        end
    end

    // ----------------------------------------------------------------
    // Link flags
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            link_fault_flag <= 1'b0;
            link_inhibit_flag <= 1'b0;
            link_reinit_or_timeout_flag <= 1'b0;
            reinit_prev <= 1'b0;
            link_reinit <= 1'b0;
            silence_cnt <= 10'h000;
        end else begin
            link_fault_flag <= link_error | wr_bit(wr_ctrl,
                reg_wdata[`PSF_C_LFAULT], link_fault_flag);
            if (!booted) begin
                link_inhibit_flag <= nv_inhibit;
            end else begin
                link_inhibit_flag <= wr_bit(wr_ctrl,
                    reg_wdata[`PSF_C_INHIBIT], link_inhibit_flag);
            end
            // Silence is counted in whole ms since the last good frame
            if (link_frame_ok || !is_slave) begin
                silence_cnt <= 10'h000;
            end else if (ms_tick && silence_cnt != SILENCE_MS[9:0]) begin
                silence_cnt <= silence_cnt + 10'h001;
            end
            reinit_prev <= link_reinit_or_timeout_flag;
            if (stopped) begin
                link_reinit_or_timeout_flag <= 1'b0;
            end else if (is_slave) begin
                if (link_frame_ok) begin
                    link_reinit_or_timeout_flag <= 1'b0;
                end else if (silence_cnt == SILENCE_MS[9:0]) begin
                    link_reinit_or_timeout_flag <= 1'b1;
                end
            end else if (is_base) begin
                link_reinit_or_timeout_flag <= wr_bit(wr_ctrl,
                    reg_wdata[`PSF_C_REINIT], link_reinit_or_timeout_flag);
            end else begin
                link_reinit_or_timeout_flag <= 1'b0;
            end
            link_reinit <= is_base && sysver_ge6 && !stopped &&
                link_reinit_or_timeout_flag && !reinit_prev;
        end
    end

    // ----------------------------------------------------------------
    // Millisecond time base and clock ticks
    // ----------------------------------------------------------------
    // cascaded from one ms counter
    // Tick dividers run on while stopped, as operating flags
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ms_cnt <= 14'h0000;
            hund_cnt <= 3'h0;
            tenth_cnt <= 4'h0;
            sec_cnt <= 4'h0;
            hund_q <= 1'b0;
            tenth_q <= 1'b0;
            sec_q <= 1'b0;
            second_tick_clear <= 1'b0;
        end else begin
            ms_cnt <= ms_tick ? 14'h0000 : ms_cnt + 14'h0001;
            if (ms_tick) begin
                hund_cnt <= hund_edge ? 3'h0 : hund_cnt + 3'h1;
            end
            if (hund_edge) begin
                hund_q <= !hund_q;
                tenth_cnt <= tenth_edge ? 4'h0 : tenth_cnt + 4'h1;
            end
            if (tenth_edge) begin
                tenth_q <= !tenth_q;
            end
            second_tick_clear <= stopped ? 1'b0 : wr_bit(wr_tick,
                reg_wdata[`PSF_T_SCLR], second_tick_clear);
            if (second_tick_clear) begin
                sec_q <= 1'b0;
                sec_cnt <= 4'h0;
            end else if (tenth_edge) begin
                sec_cnt <= sec_edge ? 4'h0 : sec_cnt + 4'h1;
                if (sec_edge) begin
                    sec_q <= !sec_q;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Preset and fast counter flags
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            preset_modified_flag <= 1'b0;
            fc_clear_q <= 1'b0;
            fast_counter_wrap_flag <= 1'b0;
        end else begin
            if (!booted) begin
                preset_modified_flag <= nv_preset;
            end else if (preset_changed) begin
                preset_modified_flag <= 1'b1;
            end else if (program_download || loader_preset_clear) begin
                preset_modified_flag <= 1'b0;
            end
            // kept across stop, lost at power-off
            fc_clear_q <= wr_bit(wr_tick, reg_wdata[`PSF_T_FCCLR],
                fc_clear_q);
            if (fc_overflow) begin
                fast_counter_wrap_flag <= 1'b1;
            end else if (stopped || fc_hard_reset || fc_clear_q) begin
                fast_counter_wrap_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign program_run = run_control_flag;
    assign first_scan_pulse = first_flag;
    assign outputs_kill_flag = kill_flag;
    assign link_halt = is_base && link_inhibit_flag;
    assign fast_counter_clear_flag = fc_clear_q;
    assign running_indicator = run_control_flag && run_prev;
    assign second_tick = sec_q;
    assign tenth_second_tick = tenth_q;
    assign hundredth_second_tick = hund_q;
    assign ctrl_flags = {link_reinit_or_timeout_flag, link_inhibit_flag,
        link_fault_flag, program_fault_flag, carry_borrow_flag,
        kill_flag, first_flag, run_control_flag};
    assign tick_flags = {running_indicator, fast_counter_wrap_flag,
        fc_clear_q, preset_modified_flag, hund_q, tenth_q, sec_q,
        second_tick_clear};

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PSF_REG_CATCH: reg_rdata <= catch_flag;
                `PSF_REG_CTRL: reg_rdata <= ctrl_flags;
                `PSF_REG_TICK: reg_rdata <= tick_flags;
                `PSF_REG_INFO: reg_rdata <= {5'h00, sysver_ge6,
                    station_role};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// ---- bench/psf_bank_monitor.sv ----
// Checker for the special flag bank, bound to its ports
module psf_bank_monitor #(
    parameter MS_CYCLES = 10
) (
    input wire mclk, // Clock
    input wire rst_b, // Async reset, low
    input wire scan_end, // End of scan
    input wire [1:0] station_role, // Station role
    input wire sysver_ge6, // Version 6 or later
    input wire program_run, // Start flag
    input wire first_scan_pulse, // First scan
    input wire outputs_kill_flag, // Outputs forced off
    input wire link_halt, // Link stopped
    input wire link_reinit, // Link reinitialize pulse
    input wire running_indicator, // Running
    input wire second_tick, // 1 s clock
    input wire tenth_second_tick, // 100 ms clock
    input wire hundredth_second_tick, // 10 ms clock
    input wire [7:0] ctrl_flags, // Control flags
    input wire [7:0] tick_flags // Tick flags
);
    localparam int HUND = 5 * MS_CYCLES;
    localparam int TENTH = 50 * MS_CYCLES;
    localparam int SEC = 500 * MS_CYCLES;
    wire [2:0] tk = {second_tick, tenth_second_tick, hundredth_second_tick};
    wire [2:0] hold = {tick_flags[0], 2'b00};
    logic [31:0] age [3];
    logic seen [3];

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------
    // Cycles since each tick last changed
    // ------------------------------------------------
    // The first change after reset or after the second clear starts
    // from a fresh divider phase, so it is not measured
    for (genvar i = 0; i < 3; i++) begin : g_age
        always @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                age[i] <= 32'h0000_0000;
                seen[i] <= 1'b0;
            end else if (hold[i] || $changed(tk[i])) begin
                age[i] <= 32'h0000_0000;
                seen[i] <= !hold[i];
            end else begin
                age[i] <= age[i] + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    a_hund_half: assert property (
        $changed(tk[0]) && seen[0] |-> age[0] == HUND - 1)
        else $error("hundredth tick half period wrong");
    a_tenth_half: assert property (
        $changed(tk[1]) && seen[1] |-> age[1] == TENTH - 1)
        else $error("tenth tick half period wrong");
    a_second_half: assert property (
        $changed(tk[2]) && seen[2] |-> age[2] == SEC - 1)
        else $error("second tick half period wrong");
    a_tick_phase: assert property (
        $changed(tenth_second_tick) |-> $changed(hundredth_second_tick))
        else $error("tenth tick not on a hundredth tick edge");
    a_second_held: assert property (
        tick_flags[0] && $past(tick_flags[0]) |-> !second_tick)
        else $error("second tick high while cleared");
    a_first_start: assert property (
        $rose(program_run) |=> first_scan_pulse)
        else $error("no first scan pulse on start");
    a_first_ends: assert property (
        first_scan_pulse && scan_end |=> !first_scan_pulse)
        else $error("first scan pulse outlived its scan");
    a_run_indicator: assert property (
        $rose(program_run) |-> !running_indicator ##1 running_indicator)
        else $error("running indicator not one cycle after start");
    a_stop_clears: assert property (
        !program_run && !$past(program_run) |-> !first_scan_pulse
        && !outputs_kill_flag && !running_indicator
        && (ctrl_flags & 8'h9E) == 8'h00 && !tick_flags[0])
        else $error("volatile flag set while stopped");
    a_halt_base: assert property (
        link_halt == (ctrl_flags[6] && station_role == 2'h0))
        else $error("link halt does not follow inhibit at base");
    a_reinit_gate: assert property (
        link_reinit |-> station_role == 2'h0 && sysver_ge6 && program_run
        ##1 !link_reinit)
        else $error("link reinit pulse out of place");

    c_second_rise: cover property ($rose(second_tick));
    c_reinit: cover property (link_reinit);
    c_first_end: cover property ($fell(first_scan_pulse));
endmodule

// ---- bench/psf_loader_model.sv ----
// Scan cadence and link traffic from the program and loader side
module psf_loader_model #(
    parameter int SCAN_LEN = 16,
    parameter int FRAME_GAP = 20
) (
    input wire logic mclk, // Clock
    input wire logic rst_b, // Async reset, low
    input wire logic scan_en, // Run scans back to back
    input wire logic scan_kick, // End the current scan now
    input wire logic link_en, // Master keeps sending frames
    output logic scan_end, // End of scan pulse
    output logic link_frame_ok // Correct frame received
);
    int sc;
    int fc;

    // ------------------------------------------------
    // Scans and link frames
    // ------------------------------------------------
    // A silent master is modelled by link_en low, nothing else
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sc <= 0;
            fc <= 0;
            scan_end <= 1'b0;
            link_frame_ok <= 1'b0;
        end else begin
            sc <= (sc == SCAN_LEN - 1) ? 0 : sc + 1;
            fc <= (fc == FRAME_GAP - 1) ? 0 : fc + 1;
            scan_end <= scan_kick || (scan_en && sc == 0);
            link_frame_ok <= link_en && fc == 0;
        end
    end
endmodule

// ---- bench/tb_plc_special_flag_bank.sv ----
// Self-checking bench for the special flag bank
module tb_plc_special_flag_bank;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [3:0] a;
        logic [7:0] d;
        logic [7:0] m;
        logic [7:0] e;
    } psf_row_t;
    // Address, write data, read mask, expected read
    psf_row_t rows [8] = '{
        '{4'h0, 8'hA5, 8'hFF, 8'hA5}, '{4'h0, 8'h5A, 8'hFF, 8'h5A},
        '{4'h1, 8'h45, 8'hFF, 8'h45}, '{4'h1, 8'h01, 8'hFF, 8'h01},
        '{4'h2, 8'hFF, 8'hF3, 8'hA1}, '{4'h2, 8'h00, 8'hF3, 8'h80},
        '{4'h3, 8'hFF, 8'hFF, 8'h04}, '{4'h9, 8'hFF, 8'hFF, 8'h00}};
    logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, catch_in = 8'h00;
    logic [1:0] station_role = 2'h0;
    logic [8:0] pls = 9'h000;
    logic sysver_ge6 = 1'b1, nv_run = 1'b0, nv_inhibit = 1'b0;
    logic nv_preset = 1'b0, scan_en = 1'b0, scan_kick = 1'b0;
    logic link_en = 1'b0;
    logic [2:0] pv, cur;
    wire [7:0] reg_rdata, ctrl_flags, tick_flags;
    wire scan_end, link_frame_ok, program_run, first_scan_pulse;
    wire outputs_kill_flag, link_halt, link_reinit, running_indicator;
    wire fast_counter_clear_flag, second_tick, tenth_second_tick;
    wire hundredth_second_tick;
    int n_fail = 0, n_tests = 0, k, np, nr [3];

    always #50 mclk = ~mclk;

    psf_flag_bank #(.MS_CYCLES(10), .SILENCE_MS(4)) dut (.*,
        .carry_set(pls[0]), .carry_clr(pls[1]), .prog_error(pls[2]),
        .link_error(pls[3]), .preset_changed(pls[4]),
        .program_download(pls[5]), .loader_preset_clear(pls[6]),
        .fc_overflow(pls[7]), .fc_hard_reset(pls[8]));

    psf_loader_model u_far (.*);

    // ------------------------------------------------
    // Bus, pulse and compare tasks
    // ------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata & m, e);
    endtask

    task automatic pulse(input int b);
        @(posedge mclk);
        pls[b] <= 1'b1;
        @(posedge mclk);
        pls <= 9'h000;
    endtask

    task automatic kick;
        @(posedge mclk);
        scan_kick <= 1'b1;
        @(posedge mclk);
        scan_kick <= 1'b0;
        // Let the scan end land before new input edges
        @(posedge mclk);
    endtask

    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    task automatic done(input string s);
        $display("%0t: %s test finished", $time, s);
    endtask

    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // Tests
    // ------------------------------------------------
    initial begin
        do_reset;
        wr(4'h1, 8'h01);
        @(posedge mclk);
        #1;
        check({5'h00, program_run, first_scan_pulse, running_indicator},
            8'h07);
        kick;
        repeat (2) @(posedge mclk);
        #1;
        check({7'h00, first_scan_pulse}, 8'h00);
        done("start");
        for (k = 0; k < 8; k++) begin
            wr(rows[k].a, rows[k].d);
            rd_chk(rows[k].a, rows[k].m, rows[k].e);
        end
        done("register table");
        wr(4'h0, 8'h00);
        kick;
        catch_in <= 8'h08;
        repeat (3) @(posedge mclk);
        catch_in <= 8'h00;
        repeat (3) @(posedge mclk);
        rd_chk(4'h0, 8'hFF, 8'h08);
        kick;
        catch_in <= 8'h20;
        repeat (3) @(posedge mclk);
        rd_chk(4'h0, 8'hFF, 8'h28);
        done("catch");
        pulse(0);
        pulse(2);
        pulse(3);
        rd_chk(4'h1, 8'hFF, 8'h39);
        pulse(1);
        repeat (4) @(posedge mclk);
        rd_chk(4'h1, 8'hFF, 8'h31);
        wr(4'h1, 8'h15);
        check({7'h00, outputs_kill_flag}, 8'h01);
        wr(4'h2, 8'h20);
        wr(4'h1, 8'h00);
        repeat (2) @(posedge mclk);
        wr(4'h1, 8'h04);
        rd_chk(4'h1, 8'hFF, 8'h00);
        check({7'h00, fast_counter_clear_flag}, 8'h01);
        rd_chk(4'h2, 8'hA1, 8'h20);
        done("flags and stop");
        wr(4'h1, 8'h41);
        check({7'h00, link_halt}, 8'h01);
        @(posedge mclk);
        station_role <= 2'h1;
        @(posedge mclk);
        #1;
        check({7'h00, link_halt}, 8'h00);
        station_role <= 2'h0;
        for (k = 0; k < 2; k++) begin
            @(posedge mclk);
            sysver_ge6 <= k[0];
            wr(4'h1, 8'h01);
            wr(4'h1, 8'h81);
            np = 0;
            repeat (6) begin
                @(posedge mclk);
                #1;
                np += (link_reinit === 1'b1);
            end
            check(8'(np), 8'(k));
        end
        station_role <= 2'h2;
        wr(4'h1, 8'h81);
        rd_chk(4'h1, 8'hFF, 8'h01);
        station_role <= 2'h1;
        link_en <= 1'b1;
        repeat (100) @(posedge mclk);
        rd_chk(4'h1, 8'h80, 8'h00);
        link_en <= 1'b0;
        repeat (60) @(posedge mclk);
        rd_chk(4'h1, 8'h80, 8'h80);
        link_en <= 1'b1;
        repeat (30) @(posedge mclk);
        rd_chk(4'h1, 8'h80, 8'h00);
        done("link");
        pulse(4);
        rd_chk(4'h2, 8'h10, 8'h10);
        pulse(5);
        rd_chk(4'h2, 8'h10, 8'h00);
        pulse(4);
        pulse(6);
        rd_chk(4'h2, 8'h10, 8'h00);
        wr(4'h2, 8'h00);
        pulse(7);
        rd_chk(4'h2, 8'h40, 8'h40);
        pulse(8);
        rd_chk(4'h2, 8'h40, 8'h00);
        done("preset and wrap");
        station_role <= 2'h0;
        scan_en <= 1'b1;
        nr = '{0, 0, 0};
        @(posedge mclk);
        #1;
        pv = {second_tick, tenth_second_tick, hundredth_second_tick};
        repeat (10000) begin
            @(posedge mclk);
            #1;
            cur = {second_tick, tenth_second_tick, hundredth_second_tick};
            for (k = 0; k < 3; k++) begin
                nr[k] += (cur[k] === 1'b1 && pv[k] === 1'b0);
            end
            pv = cur;
        end
        check(8'(nr[0]), 8'h64);
        check(8'(nr[1]), 8'h0A);
        check(8'(nr[2]), 8'h01);
        done("ticks");
        nv_run <= 1'b1;
        nv_inhibit <= 1'b1;
        nv_preset <= 1'b1;
        do_reset;
        rd_chk(4'h1, 8'h41, 8'h41);
        rd_chk(4'h2, 8'h30, 8'h10);
        done("power cycle");
        close_out;
    end

    initial begin
        repeat (40000) @(posedge mclk);
        n_fail++;
        close_out;
    end
endmodule

bind psf_flag_bank psf_bank_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.*);
